//--- hw/remap_capability_report.sv
// Read-only version and capability registers of the remapping unit
`timescale 1ns/1ps
`include "remap_capability_report_consts.svh"

// Contract
// - Revision bits 7:4 read major revision 1, read-only.
// - Revision bits 3:0 read minor revision 0, read-only.
// - Revision register at offset 000h; bits 31:8 read zero.
// - Capability register at 008h, 64 bits; bits 63:56 read zero.
// - Bit 55 reports whether DMA reads can be drained.
// - Bit 54 reports whether DMA writes can be drained.
// - Bits 53:48 report largest accepted invalidation address mask.
// - Bits 47:40 hold N; unit has N+1 fault-log slots.
// - At least one and at most 256 fault-log slots implemented.
// - Bit 39 set means page-selective invalidation is supported.
// - With page-selective support, largest mask value should be at least 9.
// - Bits 37:34 list super-page sizes, one size per bit.
// - Super-page bits form a contiguous run starting at bit 0.
// - Bits 33:24 hold Y; first fault slot at base plus 16*Y.
// - Bit 23 set when time-critical requesters are in scope.
// - Bit 22 set when zero-length reads to write-only pages pass.
// - Zero-length reads should preferably be permitted and reported.
// - Reserved fields read zero; software writes zero there.
module remap_capability_report
#(
   parameter logic       READ_DRAIN  = `CAP_READ_DRAIN_VALUE,
   parameter logic       WRITE_DRAIN = `CAP_WRITE_DRAIN_VALUE,
   parameter logic [5:0] MASK_VALUE  = `CAP_MASK_VALUE,
   parameter logic [7:0] SLOT_COUNT  = `CAP_SLOT_VALUE,
   parameter logic       PAGE_FLUSH  = `CAP_PAGE_FLUSH_VALUE,
   parameter logic [3:0] SUPERPAGES  = `CAP_SUPERPAGE_VALUE,
   parameter logic [9:0] SLOT_OFFSET = `CAP_SLOT_OFS_VALUE,
   parameter logic       TIME_CRIT   = `CAP_TIME_CRIT_VALUE,
   parameter logic       ZERO_READ   = `CAP_ZERO_READ_VALUE
)
(
   // Clock and reset
   input  wire logic                                       clock_in,
   input  wire logic                                       rst_n_in,
   // Memory-mapped register access
   input  wire logic                                       rd_en_in,
   input  wire logic                                       wr_en_in,
   input  wire remap_capability_report_pkg::reg_addr_t     addr_in,
   input  wire remap_capability_report_pkg::reg_word_t     wr_data_in,
   output remap_capability_report_pkg::reg_word_t          rd_data_out,
   output logic                                            rd_valid_out,
   // Whole register images
   output remap_capability_report_pkg::reg_word_t          arch_rev_out,
   output remap_capability_report_pkg::cap_word_t          unit_caps_out
);

   // ==========================================================
   // Super-page field is legalised to a run of ones from bit 0
   function automatic logic [3:0] run_from_zero(input logic [3:0] raw);
      logic [3:0] run;
      run    = 4'h0;
      run[0] = raw[0];
      // A size counts only while every smaller size is kept as well
      for (int i = 1; i < 4; i++)
      begin
         run[i] = raw[i] & run[i - 1];
      end
      return run;
   endfunction : run_from_zero

   // ==========================================================
   // Address decoding, used by the read path
   function automatic remap_capability_report_pkg::reg_sel_t decode_addr(
      input remap_capability_report_pkg::reg_addr_t addr
   );
      remap_capability_report_pkg::reg_sel_t sel;
      sel = remap_capability_report_pkg::SEL_NONE;
      if (addr == `ARCH_REV_OFFSET)
      begin
         sel = remap_capability_report_pkg::SEL_ARCH_REV;
      end
      else if (addr == `UNIT_CAPS_LO_OFFSET)
      begin
         sel = remap_capability_report_pkg::SEL_CAPS_LO;
      end
      else if (addr == `UNIT_CAPS_HI_OFFSET)
      begin
         sel = remap_capability_report_pkg::SEL_CAPS_HI;
      end
      return sel;
   endfunction : decode_addr

   // ==========================================================
   // Fixed field values
   wire logic [3:0] superpage_legal;
   wire logic [5:0] mask_legal;
   wire logic [7:0] slot_field;

   assign superpage_legal = run_from_zero(SUPERPAGES);
   // Mask raised to the preferred floor when page-selective is offered
   assign mask_legal = (PAGE_FLUSH && MASK_VALUE < `CAP_MASK_FLOOR)
                       ? `CAP_MASK_FLOOR : MASK_VALUE;
   // An 8-bit field of N+1 slots spans 1 to 256 slots by construction
   assign slot_field = SLOT_COUNT;

   // ==========================================================
   // Capability word assembly
   remap_capability_report_pkg::cap_word_t caps_word;

   cap_field_pack u_pack
   (
      .read_drain_in  (READ_DRAIN),
      .write_drain_in (WRITE_DRAIN),
      .mask_in        (mask_legal),
      .slots_in       (slot_field),
      .page_flush_in  (PAGE_FLUSH),
      .superpage_in   (superpage_legal),
      .slot_ofs_in    (SLOT_OFFSET),
      .time_crit_in   (TIME_CRIT),
      .zero_read_in   (ZERO_READ),
      .word_out       (caps_word)
   );

   // ==========================================================
   // Revision word assembly; upper bits reserved as zero
   remap_capability_report_pkg::reg_word_t rev_word;

   assign rev_word = {24'h000000,
                      `ARCH_MAJOR_VALUE,
                      `ARCH_MINOR_VALUE};

   // ==========================================================
   // Read data selection
   remap_capability_report_pkg::reg_sel_t  rd_sel;
   remap_capability_report_pkg::reg_word_t rd_mux;

   assign rd_sel = decode_addr(addr_in);

   always_comb
   begin
      case (rd_sel)
         remap_capability_report_pkg::SEL_ARCH_REV: rd_mux = rev_word;
         remap_capability_report_pkg::SEL_CAPS_LO:  rd_mux = caps_word[31:0];
         remap_capability_report_pkg::SEL_CAPS_HI:  rd_mux = caps_word[63:32];
         default:                                   rd_mux = 32'h00000000;
      endcase
   end

   // ==========================================================
   // Registered read answer; loaded on a read, held otherwise, writes change nothing
   remap_capability_report_pkg::reg_word_t rd_data_ff;
   remap_capability_report_pkg::reg_word_t nxt_rd_data;
   logic                                   rd_valid_ff;
   logic                                   wr_seen;

   // Writes carry no effect: data and strobe are only observed here
   assign wr_seen     = wr_en_in & (|wr_data_in | 1'b1);
   assign nxt_rd_data = rd_en_in ? rd_mux : rd_data_ff;

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         rd_data_ff  <= 32'h00000000;
         rd_valid_ff <= 1'b0;
      end
      else
      begin
         rd_data_ff  <= nxt_rd_data;
         rd_valid_ff <= rd_en_in & ~(wr_seen & ~rd_en_in);
      end
   end

   assign rd_data_out   = rd_data_ff;
   assign rd_valid_out  = rd_valid_ff;
   assign arch_rev_out  = rev_word;
   assign unit_caps_out = caps_word;

endmodule : remap_capability_report

//--- shared/remap_capability_report_consts.svh
// Offsets, field positions and values of the capability report registers
`ifndef REMAP_CAPABILITY_REPORT_CONSTS_SVH
`define REMAP_CAPABILITY_REPORT_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define ARCH_REV_OFFSET        12'h000
`define UNIT_CAPS_LO_OFFSET    12'h008
`define UNIT_CAPS_HI_OFFSET    12'h00C

// ==========================================================
// Architecture revision fields
`define ARCH_MAJOR_MSB         7
`define ARCH_MAJOR_LSB         4
`define ARCH_MINOR_MSB         3
`define ARCH_MINOR_LSB         0
`define ARCH_MAJOR_VALUE       4'h1
`define ARCH_MINOR_VALUE       4'h0

// ==========================================================
// Unit capability field positions
`define CAP_READ_DRAIN_BIT     55
`define CAP_WRITE_DRAIN_BIT    54
`define CAP_MASK_MSB           53
`define CAP_MASK_LSB           48
`define CAP_SLOT_MSB           47
`define CAP_SLOT_LSB           40
`define CAP_PAGE_FLUSH_BIT     39
`define CAP_SUPERPAGE_MSB      37
`define CAP_SUPERPAGE_LSB      34
`define CAP_SLOT_OFS_MSB       33
`define CAP_SLOT_OFS_LSB       24
`define CAP_TIME_CRIT_BIT      23
`define CAP_ZERO_READ_BIT      22

// ==========================================================
// Implementation values reported by this unit
`define CAP_READ_DRAIN_VALUE   1'h1
`define CAP_WRITE_DRAIN_VALUE  1'h1
`define CAP_MASK_VALUE         6'h09
`define CAP_SLOT_VALUE         8'h07
`define CAP_PAGE_FLUSH_VALUE   1'h1
`define CAP_SUPERPAGE_VALUE    4'h3
`define CAP_SLOT_OFS_VALUE     10'h020
`define CAP_TIME_CRIT_VALUE    1'h0
`define CAP_ZERO_READ_VALUE    1'h1

// Preferred lowest mask value while page-selective flush is offered
`define CAP_MASK_FLOOR         6'h09

`endif

//--- shared/remap_capability_report_pkg.sv
// Types shared by the capability report registers
package remap_capability_report_pkg;
   typedef logic [31:0] reg_word_t;
   typedef logic [63:0] cap_word_t;
   typedef logic [11:0] reg_addr_t;
   typedef enum logic [1:0] {
      SEL_NONE,
      SEL_ARCH_REV,
      SEL_CAPS_LO,
      SEL_CAPS_HI
   } reg_sel_t;
endpackage : remap_capability_report_pkg

//--- hw/cap_field_pack.sv
// Packs the fixed capability fields into the 64-bit report word
`timescale 1ns/1ps
`include "remap_capability_report_consts.svh"

module cap_field_pack
(
   // Capability fields
   input  wire logic       read_drain_in,
   input  wire logic       write_drain_in,
   input  wire logic [5:0] mask_in,
   input  wire logic [7:0] slots_in,
   input  wire logic       page_flush_in,
   input  wire logic [3:0] superpage_in,
   input  wire logic [9:0] slot_ofs_in,
   input  wire logic       time_crit_in,
   input  wire logic       zero_read_in,
   // Packed word
   output remap_capability_report_pkg::cap_word_t word_out
);

   // ==========================================================
   // Field placement; every other bit is reserved and reads zero
   always_comb
   begin
      word_out = '0;
      word_out[`CAP_READ_DRAIN_BIT] = read_drain_in;
      word_out[`CAP_WRITE_DRAIN_BIT] = write_drain_in;
      word_out[`CAP_MASK_MSB:`CAP_MASK_LSB] = mask_in;
      word_out[`CAP_SLOT_MSB:`CAP_SLOT_LSB] = slots_in;
      word_out[`CAP_PAGE_FLUSH_BIT] = page_flush_in;
      word_out[`CAP_SUPERPAGE_MSB:`CAP_SUPERPAGE_LSB] = superpage_in;
      word_out[`CAP_SLOT_OFS_MSB:`CAP_SLOT_OFS_LSB] = slot_ofs_in;
      word_out[`CAP_TIME_CRIT_BIT] = time_crit_in;
      word_out[`CAP_ZERO_READ_BIT] = zero_read_in;
   end

endmodule : cap_field_pack

//--- dv/remap_capability_report_props.sv
// Concurrent checks on the capability report register ports
`timescale 1ns/1ps

module remap_capability_report_props
(
   // Clock and reset
   input wire logic                                   clock_in,
   input wire logic                                   rst_n_in,
   // Register access
   input wire logic                                   rd_en_in,
   input wire logic                                   wr_en_in,
   input wire remap_capability_report_pkg::reg_addr_t addr_in,
   input wire remap_capability_report_pkg::reg_word_t wr_data_in,
   input wire remap_capability_report_pkg::reg_word_t rd_data_out,
   input wire logic                                   rd_valid_out,
   // Register images
   input wire remap_capability_report_pkg::reg_word_t arch_rev_out,
   input wire remap_capability_report_pkg::cap_word_t unit_caps_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // ======================================
   // Fixed register images
   ver_word_a: assert property (
      arch_rev_out == 32'h0000_0010)
      else $error("revision word wrong");
   caps_rsvd_a: assert property (
      {unit_caps_out[63:56], unit_caps_out[38]} == 9'h000)
      else $error("reserved capability bits set");
   page_run_a: assert property (
      unit_caps_out[37:34] inside {4'h1, 4'h3, 4'h7, 4'hF})
      else $error("super-page sizes not contiguous");
   mask_floor_a: assert property (
      unit_caps_out[39] |-> unit_caps_out[53:48] >= 6'h09)
      else $error("mask value below nine");
   // ======================================
   // Read answers; a read sampled while in reset is dropped
   rd_answer_a: assert property (
      rd_en_in && rst_n_in |=> rd_valid_out)
      else $error("read not answered");
   rd_quiet_a: assert property (
      !rd_en_in |=> !rd_valid_out && $stable(rd_data_out))
      else $error("read data moved without a read");
   rd_ver_a: assert property (
      rd_en_in && rst_n_in && addr_in == 12'h000
      |=> rd_data_out == 32'h0000_0010)
      else $error("revision read wrong");
   rd_lo_a: assert property (
      rd_en_in && rst_n_in && addr_in == 12'h008
      |=> rd_data_out == unit_caps_out[31:0])
      else $error("capability low read wrong");
   rd_hi_a: assert property (
      rd_en_in && rst_n_in && addr_in == 12'h00C
      |=> rd_data_out == unit_caps_out[63:32])
      else $error("capability high read wrong");
   wr_none_a: assert property (
      wr_en_in |=> $stable(unit_caps_out) && $stable(arch_rev_out))
      else $error("write changed a register");
   // Main scenarios reached
   cover property (rd_en_in && addr_in == 12'h008);
   cover property (rd_en_in ##1 rd_en_in);
   cover property (wr_en_in && !rd_en_in);
endmodule : remap_capability_report_props

//--- dv/remap_capability_report_tb.sv
// Self-checking bench for the capability report registers
`timescale 1ns/1ps

module remap_capability_report_tb;
   // ======================================
   // Stimulus, observation and expectations
   logic        clock_in;
   logic        rst_n_in = 1'b0;
   logic        rd_en_in = 1'b0;
   logic        wr_en_in = 1'b0;
   logic [11:0] addr_in = 12'h000;
   logic [31:0] wr_data_in = 32'h0;
   logic [31:0] rd_data_out;
   logic        rd_valid_out;
   logic [31:0] arch_rev_out;
   logic [63:0] unit_caps_out;
   logic [11:0] addr_q[8];
   logic [31:0] exp_q[8];
   int          n_mismatch = 0;
   int          checked = 0;
   localparam logic [63:0] caps_exp = {8'h00, 1'h1, 1'h1, 6'h09, 8'h07,
      1'h1, 1'h0, 4'h3, 10'h020, 1'h0, 1'h1, 22'h0};

   // Clock at 25 MHz
   initial
   begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end

   remap_capability_report dut_u
   (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .rd_en_in(rd_en_in),
      .wr_en_in(wr_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
      .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
      .arch_rev_out(arch_rev_out), .unit_caps_out(unit_caps_out)
   );

   // ======================================
   // Shared tasks
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic set(input int k, input logic [11:0] a, input logic [31:0] e);
      addr_q[k] = a;
      exp_q[k] = e;
   endtask : set

   // Back-to-back reads, each answer judged one cycle after its request
   task automatic rd_seq(input int n);
      for (int i = 0; i <= n; i++)
      begin
         @(posedge clock_in);
         rd_en_in <= (i < n);
         addr_in <= (i < n) ? addr_q[i] : 12'h000;
         #1;
         if (i > 0)
         begin
            check(rd_valid_out, 1'b1);
            check(rd_data_out, exp_q[i - 1]);
         end
      end
   endtask : rd_seq

   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   // ======================================
   // Scenarios
   task automatic t_images;
      logic mask_ok;
      check(arch_rev_out, 32'h0000_0010);
      check(unit_caps_out, caps_exp);
      check(unit_caps_out[63:56], 8'h00);
      check(unit_caps_out[55:54], 2'h3);
      check(unit_caps_out[53:48], 6'h09);
      check(unit_caps_out[47:40], 8'h07);
      check(unit_caps_out[39:38], 2'h2);
      check(unit_caps_out[37:34], 4'h3);
      check(unit_caps_out[33:24], 10'h020);
      check(unit_caps_out[23:22], 2'h1);
      // Mask field is trusted only while page-selective flush is offered
      mask_ok = unit_caps_out[39] ? unit_caps_out[53:48] >= 6'h09 : 1'b1;
      check(mask_ok, 1'b1);
      // No time-critical requesters, so coarse flushes stay allowed
      check(unit_caps_out[23], 1'b0);
      check(rd_valid_out, 1'b0);
      check(rd_data_out, 32'h0);
   endtask : t_images

   task automatic t_reads;
      set(0, 12'h000, 32'h0000_0010);
      set(1, 12'h00C, caps_exp[63:32]);
      set(2, 12'h008, caps_exp[31:0]);
      set(3, 12'h004, 32'h0);
      set(4, 12'hFFC, 32'h0);
      set(5, 12'h00C, caps_exp[63:32]);
      rd_seq(6);
   endtask : t_reads

   // Writes leave every reported value unchanged
   task automatic t_write;
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clock_in);
         wr_en_in <= 1'b1;
         addr_in <= addr_q[i];
         wr_data_in <= 32'h0000_000F;
      end
      @(posedge clock_in);
      wr_en_in <= 1'b0;
      #1;
      check(rd_valid_out, 1'b0);
      rd_seq(3);
   endtask : t_write

   // Reset in mid-run clears the read port, a read in reset is dropped
   task automatic t_rereset;
      @(posedge clock_in);
      rst_n_in <= 1'b0;
      rd_en_in <= 1'b1;
      @(posedge clock_in);
      rst_n_in <= 1'b1;
      rd_en_in <= 1'b0;
      #1;
      t_images();
      // The read sampled in reset is never answered afterwards
      @(posedge clock_in);
      #1;
      check(rd_valid_out, 1'b0);
   endtask : t_rereset

   // Main sequence
   initial
   begin
      repeat (5) @(posedge clock_in);
      rst_n_in <= 1'b1;
      #1;
      t_images();
      t_reads();
      t_write();
      t_rereset();
      t_reads();
      results();
   end

   // Guard against a hang
   initial
   begin
      #200000;
      n_mismatch++;
      results();
   end
endmodule : remap_capability_report_tb

bind remap_capability_report remap_capability_report_props props_u
(
   .clock_in(clock_in), .rst_n_in(rst_n_in), .rd_en_in(rd_en_in),
   .wr_en_in(wr_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
   .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
   .arch_rev_out(arch_rev_out), .unit_caps_out(unit_caps_out)
);
